// ===== rtl/sdr_consts.svh
// named constants of the serial diagnosis read-out block
// assumes inclusion by bare name from package and modules
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH
// ==========================================================
// frame layout
`define SDR_FRAME_BITS 5'h10
`define SDR_CNT_ZERO 5'h00
`define SDR_WORD_ZERO 16'h0000
// ==========================================================
// control byte codes
`define SDR_CMD_DIAG_LO 8'h00
`define SDR_CMD_DIAG_HI 8'h0f
`define SDR_CMD_RDBK_LO 8'hc0
`define SDR_CMD_RDBK_HI 8'hcf
`define SDR_NIB_ECHO 4'ha
`define SDR_NIB_LOW 4'h0
`define SDR_NIB_HIGH 4'hf
// ==========================================================
// two-bit diagnosis codes
`define SDR_DG_OK 2'b11
`define SDR_DG_OVL 2'b10
`define SDR_DG_OPEN 2'b01
`define SDR_DG_GND 2'b00
// ==========================================================
// synchroniser width: sclk, cs, si, 16 inputs, 48 fault lines
`define SDR_SYNC_W 67
`endif

// ===== rtl/sdr_pkg.sv
// types shared by the serial diagnosis read-out block
// assumes sdr_consts.svh on the include path
`include "sdr_consts.svh"
package sdr_pkg;
	// ==========================================================
	// prepared answer for the next frame
	typedef enum logic [2:0] {
		SDR_IDLE = 3'b000,    // answer reads zero
		SDR_DIAG_LO = 3'b001, // two-bit diagnosis, channels 1-8
		SDR_DIAG_HI = 3'b010, // two-bit diagnosis, channels 9-16
		SDR_RDBK_LO = 3'b011, // read-back, channels 1-8
		SDR_RDBK_HI = 3'b100, // read-back, channels 9-16
		SDR_ECHO = 3'b101     // si looped to so
	} sdr_mode_e;
	// ==========================================================
	// per-channel fault condition lines
	typedef struct packed {
		logic [15:0] ovl;  // overload or overtemperature
		logic [15:0] open; // open load
		logic [15:0] gnd;  // short to ground
	} sdr_fault_s;
	// synchronised serial pins
	typedef struct packed {
		logic sclk; // serial clock
		logic cs;   // chip select, active high here
		logic si;   // serial data in
	} sdr_spi_s;
endpackage

// ===== rtl/sdr_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes level inputs only; resets every stage to zero
`timescale 1ns/10ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_sync #(
	parameter int W = `SDR_SYNC_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // first stage, read only by q
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;
	// ==========================================================
	// next values
	always_comb begin
		meta_nxt = d;
		q_nxt = meta_r;
	end
	// registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= meta_nxt;
			q <= q_nxt;
		end
	end
endmodule // sdr_sync
`default_nettype wire

// ===== rtl/sdr_top.sv
// serial command decoder for the diagnosis read-out options
// assumes spi mode 0 master, sclk well below SYS_CLK / 4
`timescale 1ns/10ps
`default_nettype none
`include "sdr_consts.svh"
module sdr_top (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// serial pins
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SI,
	output logic SO,
	output logic SO_EN,
	// channel state
	input wire logic [15:0] IN_PAR,
	input wire sdr_pkg::sdr_fault_s FAULT
);
	// ==========================================================
	// synchronised pins
	logic [`SDR_SYNC_W-1:0] sync_q;
	sdr_pkg::sdr_spi_s spi;     // synced serial pins
	logic [15:0] in_s;          // synced parallel inputs
	sdr_pkg::sdr_fault_s flt_s; // synced fault lines
	sdr_sync #(.W(`SDR_SYNC_W)) u_sync (
		.clk(SYS_CLK),
		.rst(RESET),
		.d({SCLK, ~CS_N, SI, IN_PAR, FAULT}),
		.q(sync_q)
	);
	assign {spi, in_s, flt_s} = sync_q;
	// ==========================================================
	// state
	logic sclk_d_r, sclk_d_nxt;     // previous sclk level
	logic cs_d_r, cs_d_nxt;         // previous cs level
	logic [15:0] rx_r, rx_nxt;      // received bits
	logic [15:0] tx_r, tx_nxt;      // answer being shifted
	logic [4:0] cnt_r, cnt_nxt;     // bits in this frame
	logic echo_r, echo_nxt;         // loop active this frame
	sdr_pkg::sdr_mode_e mode_r, mode_nxt;
	logic so_nxt, so_en_nxt;
	logic [15:0] ovl_r, ovl_nxt;    // sticky fault latches
	logic [15:0] open_r, open_nxt;
	logic [15:0] gnd_r, gnd_nxt;
	logic [15:0] clr;               // latch clear this cycle
	logic [15:0] word;              // answer loaded at cs fall
	// edge strobes, all one-cycle pulses
	wire cs_fall = spi.cs & ~cs_d_r;
	wire cs_rise = ~spi.cs & cs_d_r;
	wire sclk_up = spi.cs & spi.sclk & ~sclk_d_r;
	wire sclk_dn = spi.cs & ~spi.sclk & sclk_d_r;
	// ==========================================================
	// two-bit code of one channel; overload outranks open load
	function automatic logic [1:0] dg_code(input logic o, input logic p,
			input logic g);
		if (o)
			dg_code = `SDR_DG_OVL;
		else if (p)
			dg_code = `SDR_DG_OPEN;
		else if (g)
			dg_code = `SDR_DG_GND;
		else
			dg_code = `SDR_DG_OK;
	endfunction
	// diagnosis word of eight channels, highest channel first
	function automatic logic [15:0] dg_word(input logic [7:0] o,
			input logic [7:0] p, input logic [7:0] g);
		dg_word = `SDR_WORD_ZERO;
		for (int i = 0; i < 8; i++)
			dg_word[2*i +: 2] = dg_code(o[i], p[i], g[i]);
	endfunction
	// decode a control byte into the prepared answer
	function automatic sdr_pkg::sdr_mode_e decode(input logic [7:0] c);
		if (c[7:4] == `SDR_NIB_ECHO)
			decode = sdr_pkg::SDR_ECHO;
		else if (c == `SDR_CMD_DIAG_LO)
			decode = sdr_pkg::SDR_DIAG_LO;
		else if (c == `SDR_CMD_DIAG_HI)
			decode = sdr_pkg::SDR_DIAG_HI;
		else if (c == `SDR_CMD_RDBK_LO)
			decode = sdr_pkg::SDR_RDBK_LO;
		else if (c == `SDR_CMD_RDBK_HI)
			decode = sdr_pkg::SDR_RDBK_HI;
		else
			decode = sdr_pkg::SDR_IDLE; // unknown: answer zero
	endfunction
	// ==========================================================
	// answer word and latch clear for the frame now starting
	always_comb begin
		word = `SDR_WORD_ZERO;
		clr = `SDR_WORD_ZERO;
		case (mode_r)
			sdr_pkg::SDR_DIAG_LO: begin
				word = dg_word(ovl_r[7:0], open_r[7:0], gnd_r[7:0]);
				clr[7:0] = {8{cs_fall}};
			end
			sdr_pkg::SDR_DIAG_HI: begin
				word = dg_word(ovl_r[15:8], open_r[15:8],
					gnd_r[15:8]);
				clr[15:8] = {8{cs_fall}};
			end
			sdr_pkg::SDR_RDBK_LO: begin
				word = {in_s[7:0],
					~(ovl_r[7:0] | open_r[7:0] | gnd_r[7:0])};
			end
			sdr_pkg::SDR_RDBK_HI: begin
				word = {in_s[15:8],
					~(ovl_r[15:8] | open_r[15:8] | gnd_r[15:8])};
			end
			default: begin
				word = `SDR_WORD_ZERO; // idle and echo load zero
			end
		endcase
	end
	// ==========================================================
	// fault latches: a new event wins over a clear in one cycle
	always_comb begin
		ovl_nxt = (ovl_r & ~clr) | flt_s.ovl;
		open_nxt = (open_r & ~clr) | flt_s.open;
		gnd_nxt = (gnd_r & ~clr) | flt_s.gnd;
	end
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			ovl_r <= `SDR_WORD_ZERO;
			open_r <= `SDR_WORD_ZERO;
			gnd_r <= `SDR_WORD_ZERO;
		end else begin
			ovl_r <= ovl_nxt;
			open_r <= open_nxt;
			gnd_r <= gnd_nxt;
		end
	end
	// ==========================================================
	// serial frame: shift in on rising sclk, out on falling
	always_comb begin
		sclk_d_nxt = spi.sclk;
		cs_d_nxt = spi.cs;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		cnt_nxt = cnt_r;
		echo_nxt = echo_r;
		mode_nxt = mode_r;
		so_nxt = SO;
		so_en_nxt = spi.cs;
		if (cs_fall) begin
			// frame start: present the prepared answer msb first
			tx_nxt = word;
			so_nxt = word[15];
			cnt_nxt = `SDR_CNT_ZERO;
			echo_nxt = (mode_r == sdr_pkg::SDR_ECHO);
			if (mode_r == sdr_pkg::SDR_ECHO)
				so_nxt = spi.si;
		end else if (cs_rise) begin
			// frame end: only the control byte counts
			if (echo_r)
				mode_nxt = sdr_pkg::SDR_IDLE;
			else if (cnt_r == `SDR_FRAME_BITS)
				mode_nxt = decode(rx_r[15:8]);
			else
				mode_nxt = sdr_pkg::SDR_IDLE; // short frame dropped
			echo_nxt = 1'b0;
			rx_nxt = `SDR_WORD_ZERO;
			so_nxt = 1'b0;
		end else if (spi.cs) begin
			if (sclk_up) begin
				rx_nxt = {rx_r[14:0], spi.si};
				if (cnt_r != `SDR_FRAME_BITS)
					cnt_nxt = cnt_r + 5'h01;
			end
			if (sclk_dn) begin
				tx_nxt = {tx_r[14:0], 1'b0};
				so_nxt = tx_r[14];
			end
			// loop is a plain copy, nothing is processed
			if (echo_r)
				so_nxt = spi.si;
		end else begin
			so_nxt = 1'b0; // idle line low while deselected
		end
	end
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b0;
			rx_r <= `SDR_WORD_ZERO;
			tx_r <= `SDR_WORD_ZERO;
			cnt_r <= `SDR_CNT_ZERO;
			echo_r <= 1'b0;
			mode_r <= sdr_pkg::SDR_IDLE;
			SO <= 1'b0;
			SO_EN <= 1'b0;
		end else begin
			sclk_d_r <= sclk_d_nxt;
			cs_d_r <= cs_d_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			cnt_r <= cnt_nxt;
			echo_r <= echo_nxt;
			mode_r <= mode_nxt;
			SO <= so_nxt;
			SO_EN <= so_en_nxt;
		end
	end
	// ==========================================================
	// checks
	diag_lo_dec_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(cs_rise && !echo_r && cnt_r == `SDR_FRAME_BITS &&
		rx_r[15:8] == `SDR_CMD_DIAG_LO) |=> mode_r == sdr_pkg::SDR_DIAG_LO)
		else $error("diag low command not decoded");
	diag_hi_dec_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(cs_rise && !echo_r && cnt_r == `SDR_FRAME_BITS &&
		rx_r[15:8] == `SDR_CMD_DIAG_HI) |=> mode_r == sdr_pkg::SDR_DIAG_HI)
		else $error("diag high command not decoded");
	rdbk_dec_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(cs_rise && !echo_r && cnt_r == `SDR_FRAME_BITS &&
		rx_r[15:8] == `SDR_CMD_RDBK_LO) |=> mode_r == sdr_pkg::SDR_RDBK_LO)
		else $error("read-back low command not decoded");
	rdbk_load_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(cs_fall && mode_r == sdr_pkg::SDR_RDBK_HI) |=>
		tx_r[15:8] == $past(in_s[15:8]))
		else $error("read-back word lacks input states");
	diag_load_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(cs_fall && mode_r == sdr_pkg::SDR_DIAG_LO) |=>
		SO == $past(word[15]) && SO_EN)
		else $error("diagnosis msb not presented at frame start");
	echo_loop_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(echo_r && spi.cs && !cs_rise) |=> SO == $past(spi.si))
		else $error("echo loop does not follow si");
	latch_clr_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(cs_fall && mode_r == sdr_pkg::SDR_DIAG_HI) |=>
		ovl_r[15:8] == $past(flt_s.ovl[15:8]))
		else $error("read diagnosis latches not cleared");
	echo_once_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		(cs_rise && echo_r) |=> mode_r == sdr_pkg::SDR_IDLE && !echo_r)
		else $error("echo loop stayed closed");
	frame_cnt_a: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		cs_fall |=> cnt_r == `SDR_CNT_ZERO ##1 cnt_r <= `SDR_FRAME_BITS)
		else $error("bit counter not restarted at frame start");
endmodule // sdr_top
`default_nettype wire

// ===== sim/sdr_host_model.sv
// spi master standing in for the host controller
// assumes mode 0 and a 64 ns serial clock made from eight clk periods
`timescale 1ns/10ps
`default_nettype none
module sdr_host_model (
	// system clock
	input wire logic clk,
	// serial pins toward the device
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_en
);
	// ==========================================================
	// idle levels: clock parked low, data line high
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b1;
	end
	// ==========================================================
	// one frame; so is taken late in the high phase, since the
	// device needs a few clk after each fall to show its next bit
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx,
			output logic en_seen);
		en_seen = 1'b1;
		@(posedge clk) cs_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 15; i >= 0; i--) begin // msb first, 16 bits
			sclk <= 1'b0;
			si <= tx[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (3) @(posedge clk);
			@(negedge clk);
			rx[i] = so;
			if (so_en !== 1'b1) begin // enable must stand all frame
				en_seen = 1'b0;
			end
			@(posedge clk);
		end
		sclk <= 1'b0;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1; // one select per frame
		si <= ~tx[0]; // released line shows no stale level
		repeat (8) @(posedge clk);
	endtask
endmodule // sdr_host_model
`default_nettype wire

// ===== sim/spi_diagnosis_readout_commands_tb_top.sv
// self-checking bench for the diagnosis read-out decoder
// assumes sdr_pkg compiled first and the host model beside it
`timescale 1ns/10ps
`default_nettype none
module spi_diagnosis_readout_commands_tb_top;
	// ==========================================================
	// bench signals
	logic sys_clk, reset, sclk, cs_n, si, so, so_en;
	logic [15:0] in_par; // parallel input levels
	sdr_pkg::sdr_fault_s fault; // fault condition lines
	int fail_count, samples_checked;
	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		in_par = 16'h0000;
		fault = '0;
		fail_count = 0;
		samples_checked = 0;
	end
	always #4 sys_clk = ~sys_clk; // 125 MHz
	sdr_top dut (.SYS_CLK(sys_clk), .RESET(reset), .SCLK(sclk),
		.CS_N(cs_n), .SI(si), .SO(so), .SO_EN(so_en),
		.IN_PAR(in_par), .FAULT(fault));
	sdr_host_model host (.clk(sys_clk), .sclk(sclk), .cs_n(cs_n),
		.si(si), .so(so), .so_en(so_en));
	// ==========================================================
	// compare and framing helpers
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// single-bit results: enable seen and idle pin levels
	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// frame out, answer in; then so and enable must be back low
	task automatic frame(input logic [15:0] tx, input logic [15:0] exp);
		logic [15:0] rx;
		logic en;
		host.xfer(tx, rx, en);
		check_val(rx, exp);
		check_bit(en, 1'b1);
		check_bit(so, 1'b0);
		check_bit(so_en, 1'b0);
	endtask
	// fault lines high long enough to pass the synchroniser
	task automatic pulse(input logic [15:0] ovl, input logic [15:0] opn,
			input logic [15:0] gnd);
		@(posedge sys_clk) fault <= '{ovl: ovl, open: opn, gnd: gnd};
		repeat (6) @(posedge sys_clk);
		fault <= '0;
		repeat (6) @(posedge sys_clk);
	endtask
	// ==========================================================
	// scenarios, in one chain: each answer belongs to the prior frame
	task automatic sc_first_zero();
		frame(16'h0000, 16'h0000); // answer after reset reads zero
	endtask
	task automatic sc_diag_lo();
		pulse(16'h0009, 16'h000a, 16'h0104); // ch4 ovl beats open
		frame(16'h0f5a, 16'hff86);
	endtask
	task automatic sc_diag_hi();
		frame(16'hc0a5, 16'hfffc); // ch9 short to ground
	endtask
	task automatic sc_rdbk_lo();
		@(posedge sys_clk) in_par <= 16'h12a5;
		pulse(16'h0010, 16'h0000, 16'h0000); // ch5 fault
		frame(16'hcf3c, 16'ha5ef);
	endtask
	task automatic sc_rdbk_hi();
		frame(16'ha0c3, 16'h12ff); // ch9 latch was read
	endtask
	task automatic sc_echo();
		frame(16'h3c69, 16'h3c69); // loop of si to so
		frame(16'haf00, 16'h0000); // loop opens, zero answer
		frame(16'h5a96, 16'h5a96); // high lower nibble loops too
		frame(16'h0000, 16'h0000); // echo leaves no answer
	endtask
	task automatic sc_refused();
		pulse(16'h0010, 16'h0000, 16'h0000); // set ch5 again
		frame(16'h7000, 16'hfeff); // diag lo answer, bad code sent
		frame(16'h0000, 16'h0000); // unknown code gives zero
	endtask
	// mid-run reset: prepared answer and latches both drop
	task automatic sc_reset();
		pulse(16'h0001, 16'h0000, 16'h0000); // ch1 overload
		@(posedge sys_clk) reset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		frame(16'h0000, 16'h0000); // prepared answer dropped
		frame(16'h0000, 16'hffff); // ch1 latch cleared
	endtask
	// ==========================================================
	// verdict, the only place the run ends
	task automatic complete_run();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// hang guard: a frame takes under 200 clk
	initial begin
		repeat (6000) @(posedge sys_clk);
		fail_count++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sc_first_zero();
		sc_diag_lo();
		sc_diag_hi();
		sc_rdbk_lo();
		sc_rdbk_hi();
		sc_echo();
		sc_refused();
		sc_reset();
		complete_run();
	end
endmodule // spi_diagnosis_readout_commands_tb_top
`default_nettype wire
